// file: logic/cc_update_consts.vh
// constants for the condition code update logic
`ifndef CC_UPDATE_CONSTS_VH
`define CC_UPDATE_CONSTS_VH

// status word bit positions
`define SR_C        0
`define SR_V        1
`define SR_Z        2
`define SR_N        3
`define SR_U        4
`define SR_E        5
`define SR_L        6
`define SR_I0       8
`define SR_I1       9
`define SR_LF       15
`define SR_RESET    16'h0300

// operand bit positions
`define ACC_MSB     35
`define Y_MSB       31
`define D16_MSB     15
`define ACC_LSH_C   31
`define ACC_RSH_C   16
`define LSB         0
`define N_SAT_BIT   31
`define N_WIDE_BIT  35

// destination kinds
`define DST_ACC     2'h0
`define DST_Y       2'h1
`define DST_D16     2'h2
`define DST_SW      2'h3

// instruction classes
`define OP_NOP      5'h00
`define OP_ARITH    5'h01
`define OP_LOGIC    5'h02
`define OP_TEST     5'h03
`define OP_ASL      5'h04
`define OP_ASR      5'h05
`define OP_LSHL     5'h06
`define OP_LSHR     5'h07
`define OP_DIV      5'h08
`define OP_BFHI     5'h09
`define OP_BFLO     5'h0a
`define OP_MOVE     5'h0b
`define OP_IMPY     5'h0c
`define OP_SRAC     5'h0d
`define OP_LONG_ARITH_SHIFT_LEFT     5'h0e
`define OP_RTI      5'h0f
`define OP_TRAP     5'h10
`define OP_SWI      5'h11
`define OP_DO       5'h12
`define OP_LOOP_EXIT    5'h13
`define OP_JUMP     5'h14

// register map
`define ADDR_MODE   8'h00
`define ADDR_STATUS 8'h04
`define MODE_SA     0
`define MODE_CC     1
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// file: logic/flag_eval.v
// width-dependent negative, zero, fit and mask test terms
`timescale 1ns/1ps
`include "cc_update_consts.vh"

module flag_eval (
    // value under test
    input  wire [35:0] value,
    input  wire        accSel,
    // bit-field operand and mask
    input  wire [15:0] operand,
    input  wire [15:0] mask,
    // results
    output wire        n16,
    output wire        z16,
    output wire        z32,
    output wire        z36,
    output wire        fits16,
    output wire        allSet,
    output wire        allClr
);
    // an accumulator keeps its 16-bit word in the upper half
    wire [15:0] field = accSel ? value[31:16] : value[15:0];

    assign n16    = field[15];
    assign z16    = (field == 16'h0000);
    assign z32    = (value[31:0] == 32'h00000000);
    assign z36    = (value == 36'h000000000);
    assign fits16 = (&value[35:15]) | ~(|value[35:15]);
    assign allSet = ((operand & mask) == mask);
    assign allClr = ((operand & mask) == 16'h0000);
endmodule

// file: logic/axi_lite_slave.v
// axi4-lite slave holding the mode word and reading back status
`timescale 1ns/1ps
`include "cc_update_consts.vh"

module axi_lite_slave (
    // clock and control
    input  wire        sys_clk,
    input  wire        reset,
    input  wire        clkEn,
    // write channels
    input  wire [7:0]  awaddr,
    input  wire        awvalid,
    output reg         awready,
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    input  wire        wvalid,
    output reg         wready,
    output reg  [1:0]  bresp,
    output reg         bvalid,
    input  wire        bready,
    // read channels
    input  wire [7:0]  araddr,
    input  wire        arvalid,
    output reg         arready,
    output reg  [31:0] rdata,
    output reg  [1:0]  rresp,
    output reg         rvalid,
    input  wire        rready,
    // block state
    input  wire [15:0] statusWord,
    input  wire        nestedLoop,
    output reg         satMode_r,
    output reg         ccMode_r
);
    reg  [7:0]  awAddr_r;
    reg         awHave_r;
    reg  [31:0] wData_r;
    reg         wStrb0_r;
    reg         wHave_r;

    wire awTake = awvalid & awready;
    wire wTake  = wvalid & wready;
    wire doWr   = awHave_r & wHave_r & ~bvalid;

    always @(posedge sys_clk) begin
        if (reset) begin
            awready   <= 1'b0;
            wready    <= 1'b0;
            awHave_r  <= 1'b0;
            wHave_r   <= 1'b0;
            awAddr_r  <= 8'h00;
            wData_r   <= 32'h00000000;
            wStrb0_r  <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= `RESP_OKAY;
            arready   <= 1'b0;
            rvalid    <= 1'b0;
            rresp     <= `RESP_OKAY;
            rdata     <= 32'h00000000;
            satMode_r <= 1'b0;
            ccMode_r  <= 1'b0;
        end else if (clkEn) begin
            awready <= ~awHave_r & ~awTake & ~doWr;
            wready  <= ~wHave_r & ~wTake & ~doWr;
            if (awTake) begin
                awHave_r <= 1'b1;
                awAddr_r <= awaddr;
            end
            if (wTake) begin
                wHave_r  <= 1'b1;
                wData_r  <= wdata;
                wStrb0_r <= wstrb[0];
            end
            if (doWr) begin
                awHave_r <= 1'b0;
                wHave_r  <= 1'b0;
                bvalid   <= 1'b1;
                if (awAddr_r == `ADDR_MODE) begin
                    bresp <= `RESP_OKAY;
                    if (wStrb0_r) begin
                        satMode_r <= wData_r[`MODE_SA];
                        ccMode_r  <= wData_r[`MODE_CC];
                    end
                end else begin
                    bresp <= `RESP_SLVERR;
                end
            end else if (bvalid & bready) begin
                bvalid <= 1'b0;
            end
            arready <= ~rvalid & ~(arvalid & arready);
            if (arvalid & arready) begin
                rvalid <= 1'b1;
                rresp  <= `RESP_OKAY;
                case (araddr)
                    `ADDR_MODE: begin
                        rdata <= {29'h0, nestedLoop, ccMode_r, satMode_r};
                    end
                    `ADDR_STATUS: begin
                        rdata <= {16'h0000, statusWord};
                    end
                    default: begin
                        rdata <= 32'h00000000;
                        rresp <= `RESP_SLVERR;
                    end
                endcase
            end else if (rvalid & rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule

// file: logic/cc_update.v
// condition code and control bit update for the 16-bit core
//
// How it works
// - bad opcode trap sets both interrupt mask bits.
// - software trap sets both mask bits, arithmetic flags untouched.
// - arithmetic left shift: overflow when destination top bit changes.
// - arithmetic left shift: carry is source top bit before shifting.
// - arithmetic right shift: carry is source bit 0.
// - set-bit field test: carry when all masked bits are one.
// - clear-bit field test: carry when all masked bits are zero.
// - field operation on status word may change every masked bit.
// - division step: carry is inverse of result top bit.
// - logical left shift and rotate: carry from bit 31 or bit 15.
// - logical right shift and rotate: carry from bit 16 or bit 0.
// - interrupt return restores status flags from the popped word.
// - move to status word loads all bits; other moves change only the limit flag.
// - integer multiply: overflow when product does not fit 16 bits.
// - accumulating right shifts: negative from bit 31 or bit 35.
// - integer multiply negative: 16-bit rule when both modes zero.
// - long left shift negative: cleared in 16-bit flag mode.
// - limit flag set on overflow or on limited accumulator read.
// - 16-bit marked flags use standard rules on 16-bit width.
`timescale 1ns/1ps
`include "cc_update_consts.vh"

module cc_update (
    // clock and control
    input  wire        sys_clk,
    input  wire        reset,
    input  wire        clkEn,
    // instruction from decode
    input  wire        opValid,
    input  wire [4:0]  opCode,
    input  wire [1:0]  dstKind,
    // operands and results from the datapath
    input  wire [35:0] srcVal,
    input  wire [35:0] resVal,
    input  wire [15:0] bfMask,
    input  wire [15:0] popVal,
    input  wire [5:0]  arithFlags,
    input  wire        specialN,
    input  wire        limitReq,
    // status outputs
    output reg  [15:0] statusWord_r,
    output reg         nestedLoop_r,
    // axi4-lite register port
    input  wire [7:0]  awaddr,
    input  wire        awvalid,
    output wire        awready,
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    input  wire        wvalid,
    output wire        wready,
    output wire [1:0]  bresp,
    output wire        bvalid,
    input  wire        bready,
    input  wire [7:0]  araddr,
    input  wire        arvalid,
    output wire        arready,
    output wire [31:0] rdata,
    output wire [1:0]  rresp,
    output wire        rvalid,
    input  wire        rready
);
    reg  [15:0] srNxt;
    reg         nlNxt;
    reg         newV;
    wire        satMode;
    wire        ccMode;
    wire        accSel;
    wire        srcMsb;
    wire        resMsb;
    wire        n16;
    wire        z16;
    wire        z32;
    wire        z36;
    wire        fits16;
    wire        allSet;
    wire        allClr;

    // top bit of an operand by its kind
    function msbOf;
        input [1:0]  kind;
        input [35:0] v;
        begin
            case (kind)
                `DST_ACC: begin
                    msbOf = v[`ACC_MSB];
                end
                `DST_Y: begin
                    msbOf = v[`Y_MSB];
                end
                default: begin
                    msbOf = v[`D16_MSB];
                end
            endcase
        end
    endfunction

    assign accSel = (dstKind == `DST_ACC);
    assign srcMsb = msbOf(dstKind, srcVal);
    assign resMsb = msbOf(dstKind, resVal);

    flag_eval u_flags (
        .value   (resVal),
        .accSel  (accSel),
        .operand (srcVal[15:0]),
        .mask    (bfMask),
        .n16     (n16),
        .z16     (z16),
        .z32     (z32),
        .z36     (z36),
        .fits16  (fits16),
        .allSet  (allSet),
        .allClr  (allClr)
    );

    axi_lite_slave u_regs (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .clkEn      (clkEn),
        .awaddr     (awaddr),
        .awvalid    (awvalid),
        .awready    (awready),
        .wdata      (wdata),
        .wstrb      (wstrb),
        .wvalid     (wvalid),
        .wready     (wready),
        .bresp      (bresp),
        .bvalid     (bvalid),
        .bready     (bready),
        .araddr     (araddr),
        .arvalid    (arvalid),
        .arready    (arready),
        .rdata      (rdata),
        .rresp      (rresp),
        .rvalid     (rvalid),
        .rready     (rready),
        .statusWord (statusWord_r),
        .nestedLoop (nestedLoop_r),
        .satMode_r  (satMode),
        .ccMode_r   (ccMode)
    );

    always @* begin
        srNxt = statusWord_r;
        nlNxt = nestedLoop_r;
        newV  = 1'b0;
        if (opValid) begin
            case (opCode)
                `OP_ARITH: begin
                    srNxt[`SR_E] = arithFlags[5];
                    srNxt[`SR_U] = arithFlags[4];
                    srNxt[`SR_N] = arithFlags[3];
                    srNxt[`SR_Z] = arithFlags[2];
                    srNxt[`SR_V] = arithFlags[1];
                    srNxt[`SR_C] = arithFlags[0];
                    newV         = arithFlags[1];
                end
                `OP_LOGIC: begin
                    srNxt[`SR_N] = n16;
                    srNxt[`SR_Z] = z16;
                    srNxt[`SR_V] = 1'b0;
                end
                `OP_TEST: begin
                    srNxt[`SR_E] = arithFlags[5];
                    srNxt[`SR_U] = arithFlags[4];
                    srNxt[`SR_N] = resVal[`N_WIDE_BIT];
                    srNxt[`SR_Z] = z36;
                    srNxt[`SR_V] = 1'b0;
                    srNxt[`SR_C] = 1'b0;
                end
                `OP_ASL: begin
                    srNxt[`SR_E] = arithFlags[5];
                    srNxt[`SR_U] = arithFlags[4];
                    srNxt[`SR_N] = resMsb;
                    srNxt[`SR_Z] = accSel ? z36 : z32;
                    newV         = srcMsb ^ resMsb;
                    srNxt[`SR_V] = newV;
                    srNxt[`SR_C] = srcMsb;
                end
                `OP_ASR: begin
                    srNxt[`SR_E] = arithFlags[5];
                    srNxt[`SR_U] = arithFlags[4];
                    srNxt[`SR_N] = resMsb;
                    srNxt[`SR_Z] = accSel ? z36 : z32;
                    srNxt[`SR_V] = 1'b0;
                    srNxt[`SR_C] = srcVal[`LSB];
                end
                `OP_LSHL: begin
                    srNxt[`SR_N] = n16;
                    srNxt[`SR_Z] = z16;
                    srNxt[`SR_V] = 1'b0;
                    srNxt[`SR_C] = accSel ? srcVal[`ACC_LSH_C] : srcVal[`D16_MSB];
                end
                `OP_LSHR: begin
                    srNxt[`SR_N] = n16;
                    srNxt[`SR_Z] = z16;
                    srNxt[`SR_V] = 1'b0;
                    srNxt[`SR_C] = accSel ? srcVal[`ACC_RSH_C] : srcVal[`LSB];
                end
                `OP_DIV: begin
                    newV         = srcMsb ^ resMsb;
                    srNxt[`SR_V] = newV;
                    srNxt[`SR_C] = ~resMsb;
                end
                `OP_BFHI: begin
                    srNxt[`SR_C] = allSet;
                    if (dstKind == `DST_SW) begin
                        srNxt = (srNxt & ~bfMask) | (resVal[15:0] & bfMask);
                    end
                end
                `OP_BFLO: begin
                    srNxt[`SR_C] = allClr;
                    if (dstKind == `DST_SW) begin
                        srNxt = (srNxt & ~bfMask) | (resVal[15:0] & bfMask);
                    end
                end
                `OP_MOVE: begin
                    if (dstKind == `DST_SW) begin
                        srNxt = srcVal[15:0];
                    end
                end
                `OP_IMPY: begin
                    newV         = ~fits16;
                    srNxt[`SR_V] = newV;
                    srNxt[`SR_Z] = z16;
                    srNxt[`SR_N] = (~satMode & ~ccMode) ? n16 : specialN;
                end
                `OP_SRAC: begin
                    srNxt[`SR_N] = satMode ? resVal[`N_SAT_BIT] : resVal[`N_WIDE_BIT];
                    srNxt[`SR_Z] = z36;
                end
                `OP_LONG_ARITH_SHIFT_LEFT: begin
                    srNxt[`SR_N] = ccMode ? 1'b0 : specialN;
                    srNxt[`SR_Z] = z32;
                end
                `OP_RTI: begin
                    srNxt = popVal;
                end
                `OP_TRAP: begin
                    srNxt[`SR_I1] = 1'b1;
                    srNxt[`SR_I0] = 1'b1;
                end
                `OP_SWI: begin
                    srNxt[`SR_I1] = 1'b1;
                    srNxt[`SR_I0] = 1'b1;
                end
                `OP_DO: begin
                    // the outer loop state moves into the nesting bit
                    nlNxt         = statusWord_r[`SR_LF];
                    srNxt[`SR_LF] = 1'b1;
                end
                `OP_LOOP_EXIT: begin
                    // loop bits unwind, flags stay
                    srNxt[`SR_LF] = nestedLoop_r;
                    nlNxt         = 1'b0;
                end
                default: begin
                    srNxt = statusWord_r;
                end
            endcase
            // limit is sticky; word loads bring their own value
            if (opCode != `OP_RTI && !(opCode == `OP_MOVE && dstKind == `DST_SW)) begin
                if (newV | limitReq) begin
                    srNxt[`SR_L] = 1'b1;
                end
            end
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            statusWord_r <= `SR_RESET;
            nestedLoop_r <= 1'b0;
        end else if (clkEn) begin
            statusWord_r <= srNxt;
            nestedLoop_r <= nlNxt;
        end
    end
endmodule

// file: tb/cc_update_props.sv
// concurrent checks on the condition code block ports
`timescale 1ns/1ps
`include "cc_update_consts.vh"

module cc_update_props (
    // clock and control
    input wire        sys_clk,
    input wire        reset,
    input wire        clkEn,
    // instruction and operands
    input wire        opValid,
    input wire [4:0]  opCode,
    input wire [1:0]  dstKind,
    input wire [35:0] srcVal,
    input wire [35:0] resVal,
    input wire [15:0] bfMask,
    input wire [15:0] popVal,
    // status
    input wire [15:0] statusWord_r
);
    wire go     = opValid && clkEn;
    wire acc    = (dstKind == `DST_ACC);
    wire wide   = acc || (dstKind == `DST_Y);
    wire d16    = (dstKind == `DST_D16);
    wire srcTop = acc ? srcVal[35] : srcVal[31];
    wire resTop = acc ? resVal[35] : resVal[31];
    wire fit    = (&resVal[35:15]) || !(|resVal[35:15]);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    chk_trap_masks: assert property (go && opCode == `OP_TRAP |=> statusWord_r[9:8] == 2'h3)
        else $error("trap masks");
    chk_swi_flags: assert property (go && opCode == `OP_SWI |=> statusWord_r[9:8] == 2'h3 && $stable(statusWord_r[5:0]))
        else $error("swi flags");
    chk_asl_ovf: assert property (go && opCode == `OP_ASL && wide |=> statusWord_r[`SR_V] == $past(srcTop ^ resTop))
        else $error("asl ovf");
    chk_asl_carry: assert property (go && opCode == `OP_ASL && wide |=> statusWord_r[`SR_C] == $past(srcTop))
        else $error("asl carry");
    chk_asr_carry: assert property (go && opCode == `OP_ASR |=> statusWord_r[`SR_C] == $past(srcVal[0]))
        else $error("asr carry");
    chk_bf_set: assert property (go && opCode == `OP_BFHI && d16 |=> statusWord_r[`SR_C] == $past(&(srcVal[15:0] | ~bfMask)))
        else $error("bf carry");
    chk_div_carry: assert property (go && opCode == `OP_DIV && wide |=> statusWord_r[`SR_C] != $past(resTop))
        else $error("div carry");
    chk_lsl_carry: assert property (go && opCode == `OP_LSHL && (acc || d16) |=> statusWord_r[`SR_C] == $past(acc ? srcVal[31] : srcVal[15]))
        else $error("lsl carry");
    chk_lsr_carry: assert property (go && opCode == `OP_LSHR && (acc || d16) |=> statusWord_r[`SR_C] == $past(acc ? srcVal[16] : srcVal[0]))
        else $error("lsr carry");
    chk_rti_restore: assert property (go && opCode == `OP_RTI |=> statusWord_r[7:0] == $past(popVal[7:0]))
        else $error("rti restore");
    chk_impy_ovf: assert property (go && opCode == `OP_IMPY |=> statusWord_r[`SR_V] == !$past(fit))
        else $error("impy ovf");
    chk_flow_hold: assert property (go && (opCode == `OP_LOOP_EXIT || opCode == `OP_JUMP) |=> $stable(statusWord_r[5:0]))
        else $error("flow flags");
endmodule

bind cc_update cc_update_props props (
    .sys_clk(sys_clk), .reset(reset), .clkEn(clkEn), .opValid(opValid), .opCode(opCode),
    .dstKind(dstKind), .srcVal(srcVal), .resVal(resVal), .bfMask(bfMask), .popVal(popVal),
    .statusWord_r(statusWord_r)
);

// file: tb/tb.sv
// self-checking bench for the condition code block
`timescale 1ns/1ps
`include "cc_update_consts.vh"

module tb;
    reg         sys_clk;
    reg         reset    = 1'b1;
    reg         opValid  = 1'b0;
    reg  [4:0]  opCode   = 5'h00;
    reg  [1:0]  dstKind  = 2'h0;
    reg  [35:0] srcVal   = 36'h0;
    reg  [35:0] resVal   = 36'h0;
    reg  [15:0] bfMask   = 16'h0;
    reg  [15:0] popVal   = 16'h0;
    reg         specialN = 1'b0;
    reg  [7:0]  awaddr   = 8'h00;
    reg  [7:0]  araddr   = 8'h00;
    reg  [31:0] wdata    = 32'h0;
    reg         awvalid  = 1'b0;
    reg         wvalid   = 1'b0;
    reg         bready   = 1'b0;
    reg         arvalid  = 1'b0;
    reg         rready   = 1'b0;
    wire [15:0] statusWord_r;
    wire        nestedLoop_r;
    wire        awready;
    wire        wready;
    wire        bvalid;
    wire        arready;
    wire        rvalid;
    wire [1:0]  bresp;
    wire [1:0]  rresp;
    wire [31:0] rdata;
    wire [1:0]  nv = {statusWord_r[`SR_N], statusWord_r[`SR_V]};
    reg  [1:0]  rsp;
    reg  [31:0] rd;
    integer     errorCnt   = 0;
    integer     checkCount = 0;

    cc_update DUT (
        .sys_clk(sys_clk), .reset(reset), .clkEn(1'b1), .opValid(opValid), .opCode(opCode),
        .dstKind(dstKind), .srcVal(srcVal), .resVal(resVal), .bfMask(bfMask), .popVal(popVal),
        .arithFlags(6'h00), .specialN(specialN), .limitReq(1'b0), .statusWord_r(statusWord_r),
        .nestedLoop_r(nestedLoop_r), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic summarize;
        begin
            $display("checks %0d mismatches %0d", checkCount, errorCnt);
            if (errorCnt == 0 && checkCount > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask

    task automatic cmp(input [15:0] got, input [15:0] exp, input [8*12:1] msg);
        begin
            checkCount = checkCount + 1;
            if (got !== exp) begin
                errorCnt = errorCnt + 1;
                $display("CHECK FAILED t=%0t %0s got %h exp %h", $time, msg, got, exp);
            end
        end
    endtask

    task automatic axi(input wr, input [7:0] a, input [31:0] d);
        integer n;
        reg     busy;
        begin
            @(posedge sys_clk);
            awaddr  <= a;
            araddr  <= a;
            wdata   <= d;
            awvalid <= wr;
            wvalid  <= wr;
            bready  <= wr;
            arvalid <= !wr;
            rready  <= !wr;
            busy = 1'b1;
            for (n = 0; n < 40 && busy; n = n + 1) begin
                @(posedge sys_clk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                if (arready) arvalid <= 1'b0;
                if ((wr && bvalid) || (!wr && rvalid)) begin
                    rsp = wr ? bresp : rresp;
                    rd = rdata;
                    bready <= 1'b0;
                    rready <= 1'b0;
                    busy = 1'b0;
                end
            end
            if (busy) begin
                errorCnt = errorCnt + 1;
                $display("CHECK FAILED t=%0t no bus response", $time);
                summarize;
            end
        end
    endtask

    task automatic op(input [4:0] c, input [1:0] d, input [35:0] s, input [35:0] r, input [15:0] x, input n);
        begin
            @(posedge sys_clk);
            opValid  <= 1'b1;
            opCode   <= c;
            dstKind  <= d;
            srcVal   <= s;
            resVal   <= r;
            bfMask   <= x;
            popVal   <= x;
            specialN <= n;
            @(posedge sys_clk);
            opValid  <= 1'b0;
            @(negedge sys_clk);
        end
    endtask

    task automatic ld(input [15:0] w);
        op(`OP_MOVE, `DST_SW, {20'h0, w}, {20'h0, w}, 16'h0, 1'b0);
    endtask

    task automatic opC(input [4:0] c, input [1:0] d, input [35:0] s, input [35:0] r, input [15:0] x, input e);
        begin
            op(c, d, s, r, x, 1'b0);
            cmp(statusWord_r[`SR_C], e, "carry");
        end
    endtask

    task automatic tRegs;
        begin
            cmp(statusWord_r, `SR_RESET, "reset word");
            axi(1'b1, `ADDR_MODE, 32'h3);
            cmp(rsp, `RESP_OKAY, "mode wr");
            axi(1'b0, `ADDR_MODE, 32'h0);
            cmp(rd[15:0], 16'h0003, "mode rd");
            axi(1'b1, `ADDR_STATUS, 32'h0);
            cmp(rsp, `RESP_SLVERR, "status wr");
            axi(1'b0, 8'h08, 32'h0);
            cmp({rsp, rd[13:0]}, {`RESP_SLVERR, 14'h0}, "unmapped");
            axi(1'b0, `ADDR_STATUS, 32'h0);
            cmp(rd[15:0], `SR_RESET, "status rd");
            axi(1'b1, `ADDR_MODE, 32'h0);
        end
    endtask

    task automatic tShift;
        begin
            ld(16'h0000);
            opC(`OP_ASL, `DST_ACC, 36'h8_0000_0000, 36'h0, 16'h0, 1'b1);
            cmp({statusWord_r[`SR_L], statusWord_r[`SR_V]}, 2'b11, "ovf limit");
            opC(`OP_ASL, `DST_Y, 36'h0_8000_0000, 36'h8_8000_0000, 16'h0, 1'b1);
            cmp(statusWord_r[`SR_V], 1'b0, "y ovf");
            opC(`OP_ASR, `DST_ACC, 36'h8_0000_0001, 36'h0, 16'h0, 1'b1);
            opC(`OP_ASR, `DST_ACC, 36'h0_0000_0002, 36'h0, 16'h0, 1'b0);
            opC(`OP_LSHL, `DST_ACC, 36'h0_8000_0000, 36'h0, 16'h0, 1'b1);
            cmp(statusWord_r[`SR_V], 1'b0, "lsl ovf");
            opC(`OP_LSHL, `DST_D16, 36'h0_8000_7fff, 36'h0, 16'h0, 1'b0);
            opC(`OP_LSHR, `DST_ACC, 36'h0_0001_0000, 36'h0, 16'h0, 1'b1);
            opC(`OP_LSHR, `DST_D16, 36'h0_0001_0000, 36'h0, 16'h0, 1'b0);
            opC(`OP_DIV, `DST_ACC, 36'h0, 36'h0_ffff_ffff, 16'h0, 1'b1);
            opC(`OP_DIV, `DST_Y, 36'h0, 36'h0_8000_0000, 16'h0, 1'b0);
        end
    endtask

    task automatic tField;
        begin
            opC(`OP_BFHI, `DST_D16, 36'h0f3, 36'h0, 16'h0033, 1'b1);
            opC(`OP_BFHI, `DST_D16, 36'h0f3, 36'h0, 16'h000c, 1'b0);
            opC(`OP_BFLO, `DST_D16, 36'h0f3, 36'h0, 16'h000c, 1'b1);
            opC(`OP_BFLO, `DST_D16, 36'h0f3, 36'h0, 16'h0003, 1'b0);
            ld(16'h0000);
            op(`OP_BFHI, `DST_SW, 36'h0, 36'h6, 16'h0006, 1'b0);
            cmp(statusWord_r[2:1], 2'b11, "field sw");
            ld(16'h0002);
            op(`OP_LOGIC, `DST_D16, 36'h0, 36'h0_0000_8000, 16'h0, 1'b0);
            cmp(statusWord_r[3:1], 3'b100, "logic d16");
            op(`OP_LOGIC, `DST_ACC, 36'h0, 36'h0_0000_ffff, 16'h0, 1'b0);
            cmp(statusWord_r[3:1], 3'b010, "logic acc");
            ld(16'h0003);
            op(`OP_TEST, `DST_ACC, 36'h0, 36'h1, 16'h0, 1'b0);
            cmp(statusWord_r[1:0], 2'b00, "test vc");
        end
    endtask

    task automatic tMode;
        begin
            op(`OP_IMPY, `DST_D16, 36'h0, 36'hf_ffff_8000, 16'h0, 1'b0);
            cmp(nv, 2'b10, "impy fits");
            op(`OP_IMPY, `DST_D16, 36'h0, 36'h0_0000_8000, 16'h0, 1'b0);
            cmp(nv, 2'b11, "impy ovf");
            axi(1'b1, `ADDR_MODE, 32'h1);
            op(`OP_IMPY, `DST_D16, 36'h0, 36'h0_0000_8000, 16'h0, 1'b0);
            cmp(nv, 2'b01, "impy sat");
            op(`OP_SRAC, `DST_ACC, 36'h0, 36'h8_0000_0000, 16'h0, 1'b1);
            cmp(statusWord_r[`SR_N], 1'b0, "srac sat");
            axi(1'b1, `ADDR_MODE, 32'h2);
            op(`OP_LONG_ARITH_SHIFT_LEFT, `DST_ACC, 36'h0, 36'h0, 16'h0, 1'b1);
            cmp(statusWord_r[`SR_N], 1'b0, "long_arith_shift_left cc");
            op(`OP_IMPY, `DST_D16, 36'h0, 36'h0_0000_7fff, 16'h0, 1'b1);
            cmp(nv, 2'b10, "impy cc");
            axi(1'b1, `ADDR_MODE, 32'h0);
            op(`OP_LONG_ARITH_SHIFT_LEFT, `DST_ACC, 36'h0, 36'h0, 16'h0, 1'b1);
            cmp(statusWord_r[`SR_N], 1'b1, "long_arith_shift_left wide");
            op(`OP_SRAC, `DST_ACC, 36'h0, 36'h8_0000_0000, 16'h0, 1'b0);
            cmp(statusWord_r[`SR_N], 1'b1, "srac wide");
        end
    endtask

    task automatic tMove;
        begin
            ld(16'h0045);
            cmp(statusWord_r, 16'h0045, "move sw");
            op(`OP_MOVE, `DST_ACC, 36'hf, 36'hf, 16'h0, 1'b0);
            cmp(statusWord_r, 16'h0045, "move acc");
            op(`OP_SWI, `DST_ACC, 36'h0, 36'h0, 16'h0, 1'b0);
            cmp(statusWord_r, 16'h0345, "swi");
            ld(16'h0000);
            op(`OP_TRAP, `DST_ACC, 36'h0, 36'h0, 16'h0, 1'b0);
            cmp(statusWord_r[9:8], 2'b11, "trap");
            op(`OP_RTI, `DST_ACC, 36'h0, 36'h0, 16'h00aa, 1'b0);
            cmp(statusWord_r[7:0], 8'haa, "rti");
        end
    endtask

    task automatic tLoop;
        begin
            ld(16'h0005);
            op(`OP_DO, `DST_ACC, 36'h0, 36'h0, 16'h0, 1'b0);
            cmp({nestedLoop_r, statusWord_r}, 17'h08005, "do first");
            op(`OP_DO, `DST_ACC, 36'h0, 36'h0, 16'h0, 1'b0);
            cmp({nestedLoop_r, statusWord_r}, 17'h18005, "do nested");
            op(`OP_LOOP_EXIT, `DST_ACC, 36'h0, 36'h0, 16'h0, 1'b0);
            cmp({nestedLoop_r, statusWord_r}, 17'h08005, "exit inner");
            op(`OP_JUMP, `DST_ACC, 36'h0, 36'h0, 16'h0, 1'b0);
            op(`OP_LOOP_EXIT, `DST_ACC, 36'h0, 36'h0, 16'h0, 1'b0);
            cmp(statusWord_r, 16'h0005, "exit outer");
        end
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        @(negedge sys_clk);
        tRegs;
        tShift;
        tField;
        tMode;
        tMove;
        tLoop;
        summarize;
    end
endmodule
